/* core/lss_pkg.sv */
// Constants, register map and helpers for the line stamp and table block.
// Operation
// RL1 - First stamp word is always the marker 0xAA.
// RL2 - Second word is 0x57 for dual-mode line B, else 0x55.
// RL3 - 16-bit line counter counts captured lines, bytes in words three and four.
// RL4 - Line counter clears at reset and whenever stamping is off.
// RL5 - Sum of region pixels, three bytes LSB first, words five to seven.
// RL6 - Words eight and sixteen are always zero.
// RL7 - Count of region pixels above high threshold, words nine and ten.
// RL8 - Count of region pixels below low limit, words eleven and twelve.
// RL9 - Sum of neighbour absolute differences, words thirteen to fifteen.
// RL10 - Software sets stamp mode, low limit and high threshold registers.
// RL11 - Eight-bit format without table drops the four low sample bits.
// RL12 - Table holds 1025 byte entries at codes 0, 4 .. 4096.
// RL13 - Stored code gives its entry, others interpolate between neighbours.
// RL14 - Entry 4096 serves only as endpoint for samples 4093 to 4095.
// RL15 - Table result sits in upper bits in 10 and 12 bit formats.
// RL16 - Software writes index register, then value stores at that index.
// RL17 - Table mode register switches between mapping and truncation.
// RL18 - Enabled stamping appends sixteen words after each line.
// RL19 - Stamp bytes sit in upper bits in wider formats, zeros below.
// RL20 - Stamp follows last region pixel at once, valids stay high; a region cut short by line end stamps after one idle cycle.
// RL21 - Interpolation is lower entry plus weighted step, rounded down.
package lss_pkg;
	localparam int SMP_W = 12;
	localparam int LUT_ENTRIES = 1025;
	localparam int LUT_AW = 11;
	localparam logic [2:0] LUT_STEP = 3'h4;
	localparam int STAMP_WORDS = 16;
	localparam logic [7:0] MARK_FIRST = 8'hAA;
	localparam logic [7:0] MARK_LINE_A = 8'h55;
	localparam logic [7:0] MARK_LINE_B = 8'h57;
	// Byte offsets on the register bus.
	localparam logic [5:0] OFS_STAMP_MODE = 6'h00;
	localparam logic [5:0] OFS_STAMP_LOW = 6'h04;
	localparam logic [5:0] OFS_STAMP_HIGH = 6'h08;
	localparam logic [5:0] OFS_LUT_MODE = 6'h0C;
	localparam logic [5:0] OFS_LUT_INDEX = 6'h10;
	localparam logic [5:0] OFS_LUT_VALUE = 6'h14;
	localparam logic [5:0] OFS_OUT_FMT = 6'h18;
	localparam logic [5:0] OFS_ACQ_DUAL = 6'h1C;
	localparam logic [5:0] OFS_ROI_START = 6'h20;
	localparam logic [5:0] OFS_ROI_LEN = 6'h24;
	localparam logic [5:0] OFS_LINE_CNT = 6'h28;
	// Reset values.
	localparam logic [11:0] RST_LOW = 12'h000;
	localparam logic [11:0] RST_HIGH = 12'hFFF;
	localparam logic [12:0] RST_ROI_START = 13'h0000;
	localparam logic [12:0] RST_ROI_LEN = 13'h1000;
	// Output formats.
	localparam logic [1:0] FMT_8 = 2'h0;
	localparam logic [1:0] FMT_10 = 2'h1;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_PEND = 3'b010,
		ST_SEND = 3'b100
	} lss_state_t;

	// Places an 8-bit byte in the top bits of the active output width.
	function automatic logic [11:0] lss_place8(input logic [7:0] v, input logic [1:0] fmt);
		case (fmt)
			FMT_8: lss_place8 = {4'h0, v};
			FMT_10: lss_place8 = {2'h0, v, 2'h0};
			default: lss_place8 = {v, 4'h0};
		endcase
	endfunction : lss_place8

	// Plain truncation of a 12-bit sample to the active output width.
	function automatic logic [11:0] lss_trunc(input logic [11:0] s, input logic [1:0] fmt);
		case (fmt)
			FMT_8: lss_trunc = {4'h0, s[11:4]};
			FMT_10: lss_trunc = {2'h0, s[11:2]};
			default: lss_trunc = s;
		endcase
	endfunction : lss_trunc
endpackage : lss_pkg

/* core/lss_lut_if.sv */
// Link between the stream core and the interpolating table.
`timescale 1ns/1ps
interface lss_lut_if;
	logic wr_en;
	logic [10:0] wr_idx;
	logic [7:0] wr_val;
	logic smp_valid;
	logic [11:0] smp;
	logic res_valid;
	logic [7:0] res;
	modport core (output wr_en, wr_idx, wr_val, smp_valid, smp, input res_valid, res);
	modport lut (input wr_en, wr_idx, wr_val, smp_valid, smp, output res_valid, res);
endinterface : lss_lut_if

/* core/lss_lut.sv */
// Interpolating lookup table with one cycle of latency.
`timescale 1ns/1ps
module lss_lut (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Core side.
	lss_lut_if.lut lut
);
	import lss_pkg::*;

	logic [7:0] mem [0:LUT_ENTRIES-1];
	logic [7:0] lo_q, lo_d, hi_q, hi_d;
	logic [1:0] frac_q, frac_d;
	logic vld_q, vld_d;
	logic [10:0] idx_lo;
	logic [10:0] idx_hi;
	logic [9:0] acc;

	// RL16 store at index
	always_ff @(posedge clock_i) begin
		if (lut.wr_en) begin
			mem[lut.wr_idx] <= lut.wr_val;
		end
	end

	// RL12 entry per fourth code
	always_comb begin
		idx_lo = {1'b0, lut.smp[11:2]};
		idx_hi = idx_lo + 11'h001;
		vld_d = lut.smp_valid;
		frac_d = lut.smp[1:0];
		lo_d = mem[idx_lo];
		// RL14 top entry endpoint
		hi_d = mem[idx_hi];
	end

	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			vld_q <= 1'b0;
			lo_q <= 8'h00;
			hi_q <= 8'h00;
			frac_q <= 2'h0;
		end else begin
			vld_q <= vld_d;
			lo_q <= lo_d;
			hi_q <= hi_d;
			frac_q <= frac_d;
		end
	end

	// RL13 exact or interpolated
	// RL21 weighted sum floors
	// The weighted form never goes negative, so a falling table needs no sign handling.
	always_comb begin
		acc = 10'(lo_q) * 10'(LUT_STEP - {1'b0, frac_q}) + 10'(hi_q) * 10'(frac_q);
	end

	assign lut.res = acc[9:2];
	assign lut.res_valid = vld_q;
endmodule : lss_lut

/* core/lss_top.sv */
// Line statistics stamp and table stage with an Avalon-MM register slave.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module lss_top #(
	parameter int LINE_MAX = 4096
) (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Avalon-MM register slave.
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Sensor pixel stream.
	input wire logic pix_lval_i,
	input wire logic pix_dval_i,
	input wire logic [lss_pkg::SMP_W-1:0] pix_data_i,
	input wire logic pix_line_b_i,
	// Video output toward the grabber.
	output logic vid_lval_o,
	output logic vid_dval_o,
	output logic [lss_pkg::SMP_W-1:0] vid_data_o
);
	import lss_pkg::*;

	// The position counter is 13 bits wide.
	if (LINE_MAX < 1 || LINE_MAX > 8191) begin : g_chk
		$error("LINE_MAX out of range");
	end

	lss_lut_if lif ();

	lss_lut u_lut (
		.clock_i(clock_i),
		.rst_n_i(rst_n_i),
		.lut(lif)
	);

	// Register state.
	logic wait_q, wait_d;
	logic [31:0] rdata_q, rdata_d;
	logic stamp_en_q, stamp_en_d;
	logic [11:0] low_q, low_d;
	logic [11:0] high_q, high_d;
	logic lut_en_q, lut_en_d;
	logic [12:0] lut_idx_q, lut_idx_d;
	logic [7:0] lut_val_q, lut_val_d;
	logic [1:0] fmt_q, fmt_d;
	logic dual_q, dual_d;
	logic [12:0] roi_start_q, roi_start_d;
	logic [12:0] roi_len_q, roi_len_d;
	logic acc_en;
	logic wr_lut;

	// Stream state.
	lss_state_t st_q, st_d;
	logic [3:0] widx_q, widx_d;
	logic [12:0] pos_q, pos_d;
	logic lval_q, lval_d;
	logic any_q, any_d;
	logic done_q, done_d;
	logic first_q, first_d;
	logic [11:0] prev_q, prev_d;
	logic [23:0] sum_q, sum_d;
	logic [23:0] con_q, con_d;
	logic [15:0] nhi_q, nhi_d;
	logic [15:0] nlo_q, nlo_d;
	logic [15:0] lcnt_q, lcnt_d;
	logic [15:0] s_cnt_q, s_cnt_d;
	logic [23:0] s_sum_q, s_sum_d;
	logic [23:0] s_con_q, s_con_d;
	logic [15:0] s_hi_q, s_hi_d;
	logic [15:0] s_lo_q, s_lo_d;
	logic s_b_q, s_b_d;
	logic px1_q, px1_d;
	logic [11:0] smp1_q, smp1_d;
	logic ov_q, ov_d;
	logic [11:0] od_q, od_d;

	// Stream helpers.
	logic [13:0] roi_end;
	logic take;
	logic in_roi;
	logic roi_pix;
	logic last_roi;
	logic line_end;
	logic trig;
	logic [11:0] diff;
	logic [7:0] word;

	// Bus request is taken in the cycle that waitrequest is low.
	always_comb begin
		acc_en = !wait_q && (avs_read_i || avs_write_i);
		wr_lut = acc_en && avs_write_i && (avs_address_i == OFS_LUT_VALUE);
	end

	// Register next state; one wait state on every access.
	always_comb begin
		wait_d = !((avs_read_i || avs_write_i) && wait_q);
		rdata_d = 32'h0000_0000;
		stamp_en_d = stamp_en_q;
		low_d = low_q;
		high_d = high_q;
		lut_en_d = lut_en_q;
		lut_idx_d = lut_idx_q;
		lut_val_d = lut_val_q;
		fmt_d = fmt_q;
		dual_d = dual_q;
		roi_start_d = roi_start_q;
		roi_len_d = roi_len_q;
		// Read data is set up while waitrequest is still high.
		case (avs_address_i)
			OFS_STAMP_MODE: rdata_d = {31'h0, stamp_en_q};
			OFS_STAMP_LOW: rdata_d = {20'h0, low_q};
			OFS_STAMP_HIGH: rdata_d = {20'h0, high_q};
			OFS_LUT_MODE: rdata_d = {31'h0, lut_en_q};
			OFS_LUT_INDEX: rdata_d = {19'h0, lut_idx_q};
			OFS_LUT_VALUE: rdata_d = {24'h0, lut_val_q};
			OFS_OUT_FMT: rdata_d = {30'h0, fmt_q};
			OFS_ACQ_DUAL: rdata_d = {31'h0, dual_q};
			OFS_ROI_START: rdata_d = {19'h0, roi_start_q};
			OFS_ROI_LEN: rdata_d = {19'h0, roi_len_q};
			OFS_LINE_CNT: rdata_d = {16'h0, lcnt_q};
			default: rdata_d = 32'h0000_0000;
		endcase
		// Outside the first request cycle the last word is held, so a master may read it late.
		if (!((avs_read_i || avs_write_i) && wait_q)) begin
			rdata_d = rdata_q;
		end
		if (acc_en && avs_write_i) begin
			case (avs_address_i)
				// RL10 stamp settings
				OFS_STAMP_MODE: stamp_en_d = avs_writedata_i[0];
				OFS_STAMP_LOW: low_d = avs_writedata_i[11:0];
				OFS_STAMP_HIGH: high_d = avs_writedata_i[11:0];
				// RL17 table mode
				OFS_LUT_MODE: lut_en_d = avs_writedata_i[0];
				// RL16 index first
				OFS_LUT_INDEX: lut_idx_d = avs_writedata_i[12:0];
				OFS_LUT_VALUE: lut_val_d = avs_writedata_i[7:0];
				OFS_OUT_FMT: fmt_d = avs_writedata_i[1:0];
				OFS_ACQ_DUAL: dual_d = avs_writedata_i[0];
				OFS_ROI_START: roi_start_d = avs_writedata_i[12:0];
				OFS_ROI_LEN: roi_len_d = avs_writedata_i[12:0];
				default: ;
			endcase
		end
	end

	// Register flops.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
			stamp_en_q <= 1'b0;
			low_q <= RST_LOW;
			high_q <= RST_HIGH;
			lut_en_q <= 1'b0;
			lut_idx_q <= 13'h0000;
			lut_val_q <= 8'h00;
			fmt_q <= FMT_8;
			dual_q <= 1'b0;
			roi_start_q <= RST_ROI_START;
			roi_len_q <= RST_ROI_LEN;
		end else begin
			wait_q <= wait_d;
			rdata_q <= rdata_d;
			stamp_en_q <= stamp_en_d;
			low_q <= low_d;
			high_q <= high_d;
			lut_en_q <= lut_en_d;
			lut_idx_q <= lut_idx_d;
			lut_val_q <= lut_val_d;
			fmt_q <= fmt_d;
			dual_q <= dual_d;
			roi_start_q <= roi_start_d;
			roi_len_q <= roi_len_d;
		end
	end

	// Table write port and sample feed; entries sit one per fourth code.
	assign lif.wr_en = wr_lut;
	assign lif.wr_idx = lut_idx_q[12:2];
	assign lif.wr_val = avs_writedata_i[7:0];
	assign lif.smp_valid = roi_pix;
	assign lif.smp = pix_data_i;

	// Region decode; input pixels are ignored while the stamp is sent.
	always_comb begin
		roi_end = {1'b0, roi_start_q} + {1'b0, roi_len_q};
		take = pix_lval_i && pix_dval_i && (st_q == ST_IDLE);
		in_roi = (pos_q >= roi_start_q) && ({1'b0, pos_q} < roi_end);
		roi_pix = take && in_roi;
		last_roi = roi_pix && ({1'b0, pos_q} == roi_end - 14'h0001);
		line_end = lval_q && !pix_lval_i;
		// RL20 stamp right after region
		trig = stamp_en_q && (last_roi || (line_end && any_q && !done_q));
		diff = (pix_data_i > prev_q) ? (pix_data_i - prev_q) : (prev_q - pix_data_i);
	end

	// Statistics, stamp sequencer and line counter.
	always_comb begin
		st_d = st_q;
		widx_d = widx_q;
		pos_d = pos_q;
		lval_d = pix_lval_i;
		any_d = any_q;
		done_d = done_q;
		first_d = first_q;
		prev_d = prev_q;
		sum_d = sum_q;
		con_d = con_q;
		nhi_d = nhi_q;
		nlo_d = nlo_q;
		lcnt_d = lcnt_q;
		s_cnt_d = s_cnt_q;
		s_sum_d = s_sum_q;
		s_con_d = s_con_q;
		s_hi_d = s_hi_q;
		s_lo_d = s_lo_q;
		s_b_d = s_b_q;
		if (take) begin
			pos_d = pos_q + 13'h0001;
		end
		if (roi_pix) begin
			any_d = 1'b1;
			first_d = 1'b0;
			prev_d = pix_data_i;
			// RL5 region sum
			sum_d = sum_q + {12'h000, pix_data_i};
			// RL7 above threshold
			if (pix_data_i > high_q) begin
				nhi_d = nhi_q + 16'h0001;
			end
			// RL8 below limit
			if (pix_data_i < low_q) begin
				nlo_d = nlo_q + 16'h0001;
			end
			// RL9 neighbour differences
			if (!first_q) begin
				con_d = con_q + {12'h000, diff};
			end
		end
		// The snapshot includes the pixel taken in the same cycle.
		if (trig) begin
			done_d = 1'b1;
			s_cnt_d = lcnt_q;
			s_sum_d = sum_d;
			s_con_d = con_d;
			s_hi_d = nhi_d;
			s_lo_d = nlo_d;
			s_b_d = pix_line_b_i;
			// RL3 count lines
			lcnt_d = lcnt_q + 16'h0001;
		end
		// RL4 clear when disabled
		if (!stamp_en_q) begin
			lcnt_d = 16'h0000;
		end
		if (line_end) begin
			pos_d = 13'h0000;
			any_d = 1'b0;
			done_d = 1'b0;
			first_d = 1'b1;
			sum_d = 24'h000000;
			con_d = 24'h000000;
			nhi_d = 16'h0000;
			nlo_d = 16'h0000;
		end
		// RL18 sixteen appended words
		case (st_q)
			ST_IDLE: begin
				if (trig) begin
					st_d = ST_PEND;
				end
			end
			ST_PEND: begin
				st_d = ST_SEND;
				widx_d = 4'h0;
			end
			ST_SEND: begin
				widx_d = widx_q + 4'h1;
				if (widx_q == 4'(STAMP_WORDS - 1)) begin
					st_d = ST_IDLE;
				end
			end
			default: st_d = ST_IDLE;
		endcase
	end

	// Stamp word content by position.
	always_comb begin
		case (widx_q)
			// RL1 first marker
			4'h0: word = MARK_FIRST;
			// RL2 line marker
			4'h1: word = (dual_q && s_b_q) ? MARK_LINE_B : MARK_LINE_A;
			4'h2: word = s_cnt_q[7:0];
			4'h3: word = s_cnt_q[15:8];
			4'h4: word = s_sum_q[7:0];
			4'h5: word = s_sum_q[15:8];
			4'h6: word = s_sum_q[23:16];
			4'h8: word = s_hi_q[7:0];
			4'h9: word = s_hi_q[15:8];
			4'hA: word = s_lo_q[7:0];
			4'hB: word = s_lo_q[15:8];
			4'hC: word = s_con_q[7:0];
			4'hD: word = s_con_q[15:8];
			4'hE: word = s_con_q[23:16];
			// RL6 reserved words zero
			default: word = 8'h00;
		endcase
	end

	// Output stage: table result, truncated sample or stamp word.
	always_comb begin
		px1_d = roi_pix;
		smp1_d = pix_data_i;
		ov_d = 1'b0;
		od_d = 12'h000;
		if (st_q == ST_SEND) begin
			ov_d = 1'b1;
			// RL19 stamp in upper bits
			od_d = lss_place8(word, fmt_q);
		end else if (px1_q) begin
			ov_d = 1'b1;
			if (lut_en_q && lif.res_valid) begin
				// RL15 table byte upper bits
				od_d = lss_place8(lif.res, fmt_q);
			end else begin
				// RL11 drop low bits
				od_d = lss_trunc(smp1_q, fmt_q);
			end
		end
	end

	// Stream flops.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			st_q <= ST_IDLE;
			widx_q <= 4'h0;
			pos_q <= 13'h0000;
			lval_q <= 1'b0;
			any_q <= 1'b0;
			done_q <= 1'b0;
			first_q <= 1'b1;
			prev_q <= 12'h000;
			sum_q <= 24'h000000;
			con_q <= 24'h000000;
			nhi_q <= 16'h0000;
			nlo_q <= 16'h0000;
			lcnt_q <= 16'h0000;
			s_cnt_q <= 16'h0000;
			s_sum_q <= 24'h000000;
			s_con_q <= 24'h000000;
			s_hi_q <= 16'h0000;
			s_lo_q <= 16'h0000;
			s_b_q <= 1'b0;
			px1_q <= 1'b0;
			smp1_q <= 12'h000;
			ov_q <= 1'b0;
			od_q <= 12'h000;
		end else begin
			st_q <= st_d;
			widx_q <= widx_d;
			pos_q <= pos_d;
			lval_q <= lval_d;
			any_q <= any_d;
			done_q <= done_d;
			first_q <= first_d;
			prev_q <= prev_d;
			sum_q <= sum_d;
			con_q <= con_d;
			nhi_q <= nhi_d;
			nlo_q <= nlo_d;
			lcnt_q <= lcnt_d;
			s_cnt_q <= s_cnt_d;
			s_sum_q <= s_sum_d;
			s_con_q <= s_con_d;
			s_hi_q <= s_hi_d;
			s_lo_q <= s_lo_d;
			s_b_q <= s_b_d;
			px1_q <= px1_d;
			smp1_q <= smp1_d;
			ov_q <= ov_d;
			od_q <= od_d;
		end
	end

	// All outputs come straight from flops.
	assign avs_readdata_o = rdata_q;
	assign avs_waitrequest_o = wait_q;
	assign vid_lval_o = ov_q;
	assign vid_dval_o = ov_q;
	assign vid_data_o = od_q;
endmodule : lss_top

/* dv/lss_top_sva.sv */
// Bus handshake and stamp framing checks for the line stamp stage.
`timescale 1ns/1ps
module lss_top_sva (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Register bus.
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic avs_waitrequest_o,
	// Video output.
	input wire logic vid_lval_o,
	input wire logic vid_dval_o,
	input wire logic [11:0] vid_data_o
);
	logic [12:0] run_d;
	logic [12:0] run_q;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	// Run length of valid words; it saturates so a long line cannot wrap it.
	always_comb begin
		run_d = vid_dval_o ? run_q + {12'h000, run_q != 13'h1FFF} : 13'h0000;
	end
	always_ff @(posedge clock_i) begin
		run_q <= rst_n_i ? run_d : 13'h0000;
	end
	chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("waitrequest low too long");
	chk_wait_cause: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
		else $error("answer without request");
	chk_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
		|=> !avs_waitrequest_o)
		else $error("request not answered");
	chk_read_hold: assert property (!(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o))
		else $error("read data moved while idle");
	chk_valid_pair: assert property (vid_lval_o == vid_dval_o)
		else $error("line and data valid differ");
	chk_mark_first: assert property ($fell(vid_dval_o) && run_q >= 13'd16
		|-> $past(vid_data_o, 16) inside {12'h0AA, 12'h2A8, 12'hAA0})
		else $error("first stamp word wrong");
	chk_mark_second: assert property ($fell(vid_dval_o) && run_q >= 13'd16 |-> $past(vid_data_o, 15)
		inside {12'h055, 12'h154, 12'h550, 12'h057, 12'h15C, 12'h570})
		else $error("second stamp word wrong");
	chk_reserved_zero: assert property ($fell(vid_dval_o) && run_q >= 13'd16
		|-> $past(vid_data_o, 1) == 12'h000 && $past(vid_data_o, 9) == 12'h000)
		else $error("reserved stamp word not zero");
endmodule : lss_top_sva
bind lss_top lss_top_sva lss_top_sva_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .vid_lval_o(vid_lval_o), .vid_dval_o(vid_dval_o),
	.vid_data_o(vid_data_o));

/* dv/lss_grab_model.sv */
// Receiving end of the video taps that collects the valid words of each line.
`timescale 1ns/1ps
module lss_grab_model (
	// Clock and reset.
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Video taps.
	input wire logic vid_lval_i,
	input wire logic vid_dval_i,
	input wire logic [11:0] vid_data_i
);
	logic [11:0] words [$];
	always @(posedge clock_i) begin
		if (rst_n_i && vid_lval_i && vid_dval_i) words.push_back(vid_data_i);
	end
endmodule : lss_grab_model

/* dv/tb_top.sv */
// Self-checking bench for the line stamp and table stage.
`timescale 1ns/1ps
module tb_top;
	import lss_pkg::*;
	logic clock_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] avs_address_i = 6'h00;
	logic avs_read_i = 1'b0;
	logic avs_write_i = 1'b0;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic avs_waitrequest_o;
	logic pix_lval_i = 1'b0;
	logic pix_dval_i = 1'b0;
	logic [11:0] pix_data_i = 12'h000;
	logic pix_line_b_i = 1'b0;
	logic vid_lval_o;
	logic vid_dval_o;
	logic [11:0] vid_data_o;
	int num_errors = 0;
	int comparisons = 0;
	logic [7:0] lut_m [0:1024];
	logic [11:0] pix [0:127];
	logic [31:0] rd;
	logic [15:0] cnt_m = 16'h0;
	logic [11:0] lo_m = 12'h000;
	logic [11:0] hi_m = 12'hFFF;
	logic [1:0] fmt_m = 2'h0;
	logic lut_on = 1'b0;
	logic stamp_on = 1'b0;
	logic dual_m = 1'b0;
	logic [5:0] ra [11] = '{OFS_STAMP_MODE, OFS_STAMP_LOW, OFS_STAMP_HIGH, OFS_LUT_MODE,
		OFS_LUT_INDEX, OFS_OUT_FMT, OFS_ACQ_DUAL, OFS_ROI_START, OFS_ROI_LEN, OFS_LINE_CNT, 6'h3C};
	logic [31:0] rv [11] = '{0, 0, 32'hFFF, 0, 0, 0, 0, 0, 32'h1000, 0, 0};
	// Clock at 100 MHz.
	always #5 clock_i = ~clock_i;
	lss_top lss_top_inst (.clock_i(clock_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
		.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.pix_lval_i(pix_lval_i), .pix_dval_i(pix_dval_i), .pix_data_i(pix_data_i),
		.pix_line_b_i(pix_line_b_i), .vid_lval_o(vid_lval_o), .vid_dval_o(vid_dval_o),
		.vid_data_o(vid_data_o));
	lss_grab_model lss_grab_model_inst (.clock_i(clock_i), .rst_n_i(rst_n_i),
		.vid_lval_i(vid_lval_o), .vid_dval_i(vid_dval_o), .vid_data_i(vid_data_o));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wrap_up;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	// One bus access; the request holds until waitrequest is seen low at an edge.
	task automatic bus(input logic we, input logic [5:0] a, input logic [31:0] d);
		int i;
		avs_address_i <= a;
		avs_read_i <= !we;
		avs_write_i <= we;
		avs_writedata_i <= d;
		for (i = 0; i < 20; i++) begin
			@(posedge clock_i);
			if (avs_waitrequest_o === 1'b0) break;
		end
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
		@(posedge clock_i);
		if (i == 20) begin
			num_errors++;
			wrap_up();
		end
	endtask : bus
	function automatic logic [11:0] put8(input logic [7:0] v);
		put8 = (fmt_m == 2'h0) ? {4'h0, v} : (fmt_m == 2'h1) ? {2'h0, v, 2'h0} : {v, 4'h0};
	endfunction : put8
	// Expected output word of one region sample.
	function automatic logic [11:0] map(input logic [11:0] s);
		int lo;
		int hi;
		int f;
		f = s[1:0];
		lo = lut_m[s[11:2]];
		hi = lut_m[s[11:2] + 11'h1];
		if (!lut_on) map = (fmt_m == 2'h0) ? {4'h0, s[11:4]} : (fmt_m == 2'h1) ? {2'h0, s[11:2]} : s;
		else map = put8(8'((lo * (4 - f) + hi * f) / 4));
	endfunction : map
	// Sends one line and compares every received word with the expectation.
	task automatic line(input int n, input int st, input int ln, input logic lb);
		logic [11:0] q [$];
		logic [127:0] b;
		int sum;
		int nh;
		int nl;
		int ctr;
		int i;
		sum = 0;
		nh = 0;
		nl = 0;
		ctr = 0;
		for (i = st; i < st + ln && i < n; i++) begin
			q.push_back(map(pix[i]));
			sum += pix[i];
			nh += (pix[i] > hi_m);
			nl += (pix[i] < lo_m);
			if (i > st) ctr += (pix[i] > pix[i-1]) ? pix[i] - pix[i-1] : pix[i-1] - pix[i];
		end
		b = {8'hAA, (dual_m && lb) ? 8'h57 : 8'h55, cnt_m, sum[7:0], sum[15:8], sum[23:16], 8'h00,
			nh[7:0], nh[15:8], nl[7:0], nl[15:8], ctr[7:0], ctr[15:8], ctr[23:16], 8'h00};
		b[111:96] = {cnt_m[7:0], cnt_m[15:8]};
		for (i = 15; i >= 0 && stamp_on; i--) q.push_back(put8(b[i*8 +: 8]));
		if (stamp_on) cnt_m++;
		for (i = 0; i < n; i++) begin
			pix_lval_i <= 1'b1;
			pix_dval_i <= 1'b1;
			pix_data_i <= pix[i];
			pix_line_b_i <= lb;
			@(posedge clock_i);
		end
		pix_lval_i <= 1'b0;
		pix_dval_i <= 1'b0;
		repeat (40) @(posedge clock_i);
		check(lss_grab_model_inst.words.size(), q.size());
		for (i = 0; i < q.size(); i++) check(lss_grab_model_inst.words[i], q[i]);
		lss_grab_model_inst.words.delete();
	endtask : line
	// Main sequence: reset map, truncation, stamped lines, table, counter clear.
	initial begin
		void'($urandom(66180));
		repeat (8) @(posedge clock_i);
		rst_n_i <= 1'b1;
		@(posedge clock_i);
		bus(1'b1, OFS_LINE_CNT, 32'h1234);
		bus(1'b1, 6'h3C, 32'h5A5A);
		for (int k = 0; k < 11; k++) begin
			bus(1'b0, ra[k], 0);
			check(rd, rv[k]);
		end
		for (int k = 0; k < 4; k++) begin
			fmt_m = k;
			bus(1'b1, OFS_OUT_FMT, k);
			for (int i = 0; i < 12; i++) pix[i] = $urandom;
			line(12, 0, 12, 1'b0);
		end
		lo_m = $urandom;
		hi_m = $urandom;
		stamp_on = 1'b1;
		bus(1'b1, OFS_STAMP_LOW, lo_m);
		bus(1'b1, OFS_STAMP_HIGH, hi_m);
		bus(1'b1, OFS_STAMP_MODE, 1);
		for (int j = 0; j < 10; j++) begin
			int st;
			int ln;
			st = $urandom % 8;
			ln = 16 + $urandom % 40;
			fmt_m = $urandom % 3;
			dual_m = $urandom;
			lut_on = (j > 5) && (j != 9);
			for (int i = 0; i < st + ln; i++) pix[i] = $urandom;
			pix[st] = 12'h000;
			pix[st+1] = 12'hFFF;
			pix[st+2] = hi_m;
			pix[st+3] = lo_m;
			pix[st+4] = 12'h009;
			pix[st+5] = 12'hFFD - (j % 3);
			pix[st+6] = 12'hFFC;
			if (j == 6) begin
				for (int k = 0; k < 1025; k++) begin
					lut_m[k] = $urandom;
					bus(1'b1, OFS_LUT_INDEX, k * 4);
					bus(1'b1, OFS_LUT_VALUE, lut_m[k]);
				end
				bus(1'b0, OFS_LUT_VALUE, 0);
				check(rd, lut_m[1024]);
			end
			bus(1'b1, OFS_LUT_MODE, lut_on);
			bus(1'b1, OFS_OUT_FMT, fmt_m);
			bus(1'b1, OFS_ACQ_DUAL, dual_m);
			bus(1'b1, OFS_ROI_START, st);
			bus(1'b1, OFS_ROI_LEN, ln);
			line(st + ln, st, ln, $urandom);
		end
		bus(1'b0, OFS_LINE_CNT, 0);
		check(rd, cnt_m);
		bus(1'b1, OFS_STAMP_MODE, 0);
		bus(1'b0, OFS_LINE_CNT, 0);
		check(rd, 0);
		cnt_m = 16'h0;
		bus(1'b1, OFS_STAMP_MODE, 1);
		bus(1'b1, OFS_ROI_START, 0);
		bus(1'b1, OFS_ROI_LEN, 30);
		line(12, 0, 12, 1'b1);
		wrap_up();
	end
endmodule : tb_top
